//--- design/pic_params.svh
`ifndef PRI_PARAMS_SVH
`define PRI_PARAMS_SVH

// ****************************************
// Register offsets
// ****************************************
`define PRI_OFF_CTRL    4'h0
`define PRI_OFF_FLAG    4'h1
`define PRI_OFF_ENABLE  4'h2
`define PRI_OFF_PRIO    4'h3
`define PRI_OFF_PERIPH  4'h4
`define PRI_OFF_STATUS  4'h5

// ****************************************
// Control field positions
// ****************************************
`define PRI_BIT_GEH     0
`define PRI_BIT_GEL     1
`define PRI_BIT_PMODE   2

// ****************************************
// Reset values and vectors
// ****************************************
`define PRI_RST_CTRL    8'h00
`define PRI_RST_PRIO    8'hff
`define PRI_VEC_HIGH    16'h0008
`define PRI_VEC_LOW     16'h0018

`endif

//--- design/pic_pkg.sv
// ****************************************
// Shared types
// ****************************************
package pri_pkg;
    // Service state of the core
    typedef enum logic [1:0]
    {
        PRI_IDLE = 2'b00,
        PRI_LOW  = 2'b01,
        PRI_HIGH = 2'b10,
        PRI_BOTH = 2'b11
    } pri_level_type;
endpackage : pri_pkg

//--- design/pic_ctrl.sv
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "pic_params.svh"

module pri_ctrl
#(
    parameter int NSRC = 8
)
(
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    input  wire logic                 clkEn,
    input  wire logic [NSRC-1:0]      srcEvent,
    input  wire logic [NSRC-1:0]      pinEvent,
    input  wire logic                 retfiDone,
    input  wire logic                 vecTaken,
    input  wire logic [3:0]           addr,
    input  wire logic [7:0]           wrData,
    input  wire logic                 wrStb,
    input  wire logic                 rdStb,
    output logic      [7:0]           rdData,
    output logic                      vecReq,
    output logic      [15:0]          vecAddr,
    output pri_pkg::pri_level_type    serviceLevel
);
    import pri_pkg::*;

    // ****************************************
    // State
    // ****************************************
    logic [7:0]      ctrl;        // Global enables and mode
    logic [NSRC-1:0] flag;        // Event flags
    logic [NSRC-1:0] enable;      // Individual enables
    logic [NSRC-1:0] prio;        // Priority selects, 1 = high
    logic [NSRC-1:0] periph;      // 1 = peripheral source
    logic [NSRC-1:0] pinSync1;    // Pin synchroniser first stage
    logic [NSRC-1:0] pinSync2;    // Pin synchroniser second stage
    logic [NSRC-1:0] pinPrev;     // Edge history
    logic [NSRC-1:0] next_flag;   // Flag next value
    logic [NSRC-1:0] eligHigh;    // Eligible high sources
    logic [NSRC-1:0] eligLow;     // Eligible low sources
    logic            pMode;       // Priority mode active
    logic            geh;         // Master or high enable
    logic            gel;         // Peripheral or low enable
    logic            takeHigh;    // Accept high vector now
    logic            takeLow;     // Accept low vector now
    logic            sw;          // Software write of flags

    assign pMode = ctrl[`PRI_BIT_PMODE];
    assign geh   = ctrl[`PRI_BIT_GEH];
    assign gel   = ctrl[`PRI_BIT_GEL];
    assign sw    = wrStb && addr == `PRI_OFF_FLAG;

    // Widen a byte to the source count
    function automatic logic [NSRC-1:0] fit(input logic [7:0] v);
        fit = NSRC'(v);
    endfunction : fit

    // ****************************************
    // Eligibility
    // ****************************************
    // Gate each source by mode and global enables
    always_comb
    begin
        if (pMode)
        begin
            eligHigh = flag & enable & prio & {NSRC{geh}};
            eligLow  = flag & enable & ~prio & {NSRC{geh && gel}};
        end
        else
        begin
            // Priority selects ignored
            eligHigh = flag & enable & {NSRC{geh}} & (~periph | {NSRC{gel}});
            eligLow  = '0;
        end
    end

    // High first, low waits; nothing stacks while a vector is pending
    assign takeHigh = clkEn && !vecReq && |eligHigh;
    assign takeLow  = clkEn && !vecReq && !(|eligHigh) && |eligLow;

    // ****************************************
    // Pin synchroniser and edges
    // ****************************************
    // Two flops then an edge detector
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            pinSync1 <= '0;
            pinSync2 <= '0;
            pinPrev  <= '0;
        end
        else if (clkEn)
        begin
            pinSync1 <= pinEvent;
            pinSync2 <= pinSync1;
            pinPrev  <= pinSync2;
        end
    end

    // ****************************************
    // Flags
    // ****************************************
    // Events set flags whatever the enables; set beats clear
    always_comb
    begin
        next_flag = flag;
        if (sw)
        begin
            next_flag = fit(wrData);
        end
        next_flag = next_flag | srcEvent | (pinSync2 & ~pinPrev);
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            flag <= '0;
        end
        else if (clkEn)
        begin
            flag <= next_flag;
        end
    end

    // ****************************************
    // Configuration
    // ****************************************
    // Enable, priority and class registers
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            enable <= '0;
            prio   <= fit(`PRI_RST_PRIO);
            periph <= '0;
        end
        else if (clkEn && wrStb)
        begin
            case (addr)
                `PRI_OFF_ENABLE: enable <= fit(wrData);
                `PRI_OFF_PRIO:   prio   <= fit(wrData);
                `PRI_OFF_PERIPH: periph <= fit(wrData);
                default:         ;
            endcase
        end
    end

    // ****************************************
    // Global enables and mode
    // ****************************************
    // Acceptance clears, return sets, hardware wins over software
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            ctrl <= `PRI_RST_CTRL;
        end
        else if (clkEn)
        begin
            if (wrStb && addr == `PRI_OFF_CTRL)
            begin
                ctrl <= wrData & 8'h07;
            end
            if (takeHigh || (takeLow && !pMode))
            begin
                ctrl[`PRI_BIT_GEH] <= 1'b0;
            end
            else if (takeLow)
            begin
                ctrl[`PRI_BIT_GEL] <= 1'b0;
            end
            else if (retfiDone)
            begin
                if (!pMode || serviceLevel[1])
                begin
                    ctrl[`PRI_BIT_GEH] <= 1'b1;
                end
                else
                begin
                    ctrl[`PRI_BIT_GEL] <= 1'b1;
                end
            end
        end
    end

    // ****************************************
    // Vector request to the core
    // ****************************************
    // Registered request held until the core takes it
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            vecReq  <= 1'b0;
            vecAddr <= `PRI_VEC_HIGH;
        end
        else if (clkEn)
        begin
            if (takeHigh || takeLow)
            begin
                vecReq  <= 1'b1;
                vecAddr <= (takeLow && pMode) ? `PRI_VEC_LOW : `PRI_VEC_HIGH;
            end
            else if (vecTaken)
            begin
                vecReq <= 1'b0;
            end
        end
    end

    // ****************************************
    // Service level tracking
    // ****************************************
    // Return leaves the innermost level
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            serviceLevel <= PRI_IDLE;
        end
        else if (clkEn)
        begin
            if (takeHigh)
            begin
                serviceLevel <= pri_level_type'({1'b1, serviceLevel[0]});
            end
            else if (takeLow)
            begin
                serviceLevel <= PRI_LOW;
            end
            else if (retfiDone)
            begin
                case (serviceLevel)
                    PRI_BOTH: serviceLevel <= PRI_LOW;
                    default:  serviceLevel <= PRI_IDLE;
                endcase
            end
        end
    end

    // ****************************************
    // Register read port
    // ****************************************
    // Data valid only in the cycle after the strobe
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            rdData <= 8'h00;
        end
        else if (clkEn)
        begin
            rdData <= 8'h00;
            if (rdStb)
            begin
                case (addr)
                    `PRI_OFF_CTRL:   rdData <= ctrl;
                    `PRI_OFF_FLAG:   rdData <= 8'(flag);
                    `PRI_OFF_ENABLE: rdData <= 8'(enable);
                    `PRI_OFF_PRIO:   rdData <= 8'(prio);
                    `PRI_OFF_PERIPH: rdData <= 8'(periph);
                    `PRI_OFF_STATUS: rdData <= {5'h00, vecReq, serviceLevel};
                    default:         rdData <= 8'h00;
                endcase
            end
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    property p_vec_addr;
        @(posedge clk) disable iff (!rst_b)
        $rose(vecReq) && !$past(pMode) |-> vecAddr == `PRI_VEC_HIGH;
    endproperty
    a_vec_addr: assert property (p_vec_addr) else $error("compat vector wrong");

    property p_low_vec;
        @(posedge clk) disable iff (!rst_b)
        takeLow && pMode |=> vecAddr == `PRI_VEC_LOW && !gel;
    endproperty
    a_low_vec: assert property (p_low_vec) else $error("low vector wrong");

    property p_high_first;
        @(posedge clk) disable iff (!rst_b)
        clkEn && !vecReq && |eligHigh && |eligLow |=> vecAddr == `PRI_VEC_HIGH;
    endproperty
    a_high_first: assert property (p_high_first) else $error("low beat high");

    property p_geh_block;
        @(posedge clk) disable iff (!rst_b)
        !geh |-> !takeHigh && !takeLow;
    endproperty
    a_geh_block: assert property (p_geh_block) else $error("took with master off");

    property p_clear_en;
        @(posedge clk) disable iff (!rst_b)
        takeHigh |=> !geh;
    endproperty
    a_clear_en: assert property (p_clear_en) else $error("enable not cleared");

    property p_flag_set;
        @(posedge clk) disable iff (!rst_b)
        clkEn && srcEvent[0] |=> flag[0];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag lost");

    sequence s_pin_edge;
        clkEn && pinSync2[0] && !pinPrev[0];
    endsequence
    property p_pin_lat;
        @(posedge clk) disable iff (!rst_b)
        s_pin_edge ##1 (clkEn && enable[0] && prio[0] && geh && !vecReq && pMode) |=> vecReq;
    endproperty
    a_pin_lat: assert property (p_pin_lat) else $error("pin latency");

    property p_compat_periph;
        @(posedge clk) disable iff (!rst_b)
        !pMode && !gel |-> (eligHigh & periph) == '0;
    endproperty
    a_compat_periph: assert property (p_compat_periph) else $error("peripheral passed");

    property p_low_gate;
        @(posedge clk) disable iff (!rst_b)
        pMode && !gel |-> !takeLow;
    endproperty
    a_low_gate: assert property (p_low_gate) else $error("low passed");

    // High request taken during a low routine nests over it
    property p_preempt;
        @(posedge clk) disable iff (!rst_b)
        takeHigh && serviceLevel == PRI_LOW |=> serviceLevel == PRI_BOTH;
    endproperty
    a_preempt: assert property (p_preempt) else $error("high did not nest over low");

    // Return from a high or compatible routine restores the master or high enable
    property p_ret_high;
        @(posedge clk) disable iff (!rst_b)
        clkEn && retfiDone && !takeHigh && !takeLow && (!pMode || serviceLevel[1]) |=> geh;
    endproperty
    a_ret_high: assert property (p_ret_high) else $error("high enable not restored");

    // Return from a low routine restores the low enable
    property p_ret_low;
        @(posedge clk) disable iff (!rst_b)
        clkEn && retfiDone && !takeHigh && !takeLow && pMode && serviceLevel == PRI_LOW |=> gel;
    endproperty
    a_ret_low: assert property (p_ret_low) else $error("low enable not restored");

endmodule : pri_ctrl

//--- tb/pic_core_model.sv
`timescale 1ns/1ps
// ****************************************
// Core model: takes vectors, returns on command
// ****************************************
module pri_core_model
(
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic vecReq,
    input  wire logic slow,
    input  wire logic retCmd,
    output logic      vecTaken,
    output logic      retfiDone
);
    logic [1:0] waitCnt; // Cycles spent before accepting
    // Accept a standing vector at once, or after three cycles when slow
    always_ff @(posedge clk)
    begin
        if (!rst_b || vecTaken)
        begin
            vecTaken <= 1'b0;
            waitCnt  <= 2'h0;
        end
        else if (vecReq && waitCnt == (slow ? 2'h3 : 2'h0))
            vecTaken <= 1'b1;
        else if (vecReq)
            waitCnt <= waitCnt + 2'h1;
    end
    // Return instruction completes one cycle after the command
    always_ff @(posedge clk)
    begin
        retfiDone <= rst_b && retCmd;
    end
endmodule : pri_core_model

//--- tb/pic_ctrl_tb.sv
`timescale 1ns/1ps
// ****************************************
// Bench for the interrupt controller
// ****************************************
module pri_ctrl_tb;
    import pri_pkg::*;
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_total++; \
    $display("FAIL t=%0t got=%0h exp=%0h", $time, a, e); end end
    logic          clk = 1'b0, rst_b = 1'b0, clkEn = 1'b1, wrStb = 1'b0, rdStb = 1'b0;
    logic          slow = 1'b0, retCmd = 1'b0, rdWas = 1'b0, vecReq, vecTaken, retfiDone;
    logic [7:0]    srcEvent = '0, pinEvent = '0, wrData = '0, rdData, r, e8;
    logic [3:0]    addr = '0;
    logic [15:0]   vecAddr, e16;
    pri_level_type serviceLevel;
    int            err_total = 0, tests_run = 0, n, m;
    logic [7:0]    rq[$]; // Expected read data
    logic [15:0]   vq[$]; // Expected vectors
    always #2.5 clk = ~clk;
    pri_ctrl #(.NSRC(8)) dut_u (.clk(clk), .rst_b(rst_b), .clkEn(clkEn), .srcEvent(srcEvent),
        .pinEvent(pinEvent), .retfiDone(retfiDone), .vecTaken(vecTaken), .addr(addr),
        .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .vecReq(vecReq),
        .vecAddr(vecAddr), .serviceLevel(serviceLevel));
    pri_core_model core_u (.clk(clk), .rst_b(rst_b), .vecReq(vecReq), .slow(slow),
        .retCmd(retCmd), .vecTaken(vecTaken), .retfiDone(retfiDone));
    // ****************************************
    // Monitor: compares each result with the oldest note
    // ****************************************
    always @(posedge clk)
    begin
        if (rdWas)
        begin
            e8 = rq.pop_front();
            `CHK(rdData, e8)
        end
        if (vecReq === 1'b1 && vecTaken === 1'b1)
        begin
            e16 = (vq.size() != 0) ? vq.pop_front() : 16'hffff;
            `CHK(vecAddr, e16)
        end
        rdWas <= rdStb;
    end
    // ****************************************
    // Bus cycles and helpers
    // ****************************************
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr   <= a;
        wrData <= d;
        wrStb  <= 1'b1;
        @(posedge clk);
        wrStb <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        rdStb <= 1'b1;
        rq.push_back(d);
        @(posedge clk);
        rdStb <= 1'b0;
    endtask : rd
    task automatic pulse(input logic [7:0] b);
        @(posedge clk);
        srcEvent <= b;
        @(posedge clk);
        srcEvent <= '0;
    endtask : pulse
    task automatic ret;
        @(posedge clk);
        retCmd <= 1'b1;
        @(posedge clk);
        retCmd <= 1'b0;
    endtask : ret
    // No vector may appear
    task automatic noVec;
        repeat (6) @(negedge clk);
        `CHK(vecReq, 1'b0)
    endtask : noVec
    // Note the vector, wait for it to be raised and taken
    task automatic waitVec(input logic [15:0] a);
        vq.push_back(a);
        for (n = 0; n < 20 && vecReq !== 1'b1; n++) @(negedge clk);
        for (m = 0; m < 20 && vecReq === 1'b1; m++) @(negedge clk);
        if (n == 20 || m == 20)
        begin
            err_total++;
            test_done();
        end
    endtask : waitVec
    task automatic test_done;
        repeat (3) @(posedge clk);
        $display("Checks %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : test_done
    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        void'($urandom(32'h6b746d3d));
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        rd(4'h0, 8'h00);
        rd(4'h3, 8'hff);
        rd(4'h5, 8'h00);
        rd(4'hf, 8'h00);
        r = 8'($urandom);
        wr(4'h2, r);
        rd(4'h2, r);
        wr(4'h2, 8'h00);
        pulse(8'h01);
        rd(4'h1, 8'h01);
        noVec();
        $display("Test reset and polling done");
        wr(4'h3, 8'h00);
        wr(4'h4, 8'h02);
        wr(4'h2, 8'h03);
        wr(4'h0, 8'h02);
        pulse(8'h03);
        noVec();
        wr(4'h0, 8'h01);
        waitVec(16'h0008);
        rd(4'h0, 8'h00);
        wr(4'h1, 8'h02);
        ret();
        rd(4'h0, 8'h01);
        noVec();
        wr(4'h0, 8'h03);
        waitVec(16'h0008);
        wr(4'h1, 8'h00);
        ret();
        $display("Test compatibility mode done");
        wr(4'h3, 8'h09);
        wr(4'h2, 8'h05);
        wr(4'h4, 8'h00);
        wr(4'h0, 8'h07);
        pulse(8'h05);
        waitVec(16'h0008);
        rd(4'h5, 8'h02);
        rd(4'h0, 8'h06);
        noVec();
        wr(4'h1, 8'h04);
        ret();
        waitVec(16'h0018);
        rd(4'h0, 8'h05);
        wr(4'h1, 8'h00);
        @(posedge clk);
        slow <= 1'b1;
        pulse(8'h01);
        waitVec(16'h0008);
        rd(4'h5, 8'h03);
        `CHK(serviceLevel, PRI_BOTH)
        wr(4'h1, 8'h00);
        ret();
        rd(4'h5, 8'h01);
        ret();
        rd(4'h0, 8'h07);
        $display("Test priority levels done");
        wr(4'h0, 8'h05);
        pulse(8'h04);
        noVec();
        wr(4'h0, 8'h06);
        noVec();
        wr(4'h0, 8'h07);
        waitVec(16'h0018);
        wr(4'h1, 8'h00);
        ret();
        wr(4'h2, 8'h01);
        @(posedge clk);
        pinEvent <= 8'h01;
        waitVec(16'h0008);
        `CHK((n == 4 || n == 5), 1'b1)
        wr(4'h1, 8'h00);
        pinEvent <= 8'h00;
        ret();
        rd(4'h0, 8'h07);
        $display("Test gating and pin latency done");
        // Enable low: an event and a write must both be lost
        @(posedge clk);
        clkEn <= 1'b0;
        pulse(8'h01);
        wr(4'h0, 8'h00);
        @(posedge clk);
        clkEn <= 1'b1;
        rd(4'h1, 8'h00);
        rd(4'h0, 8'h07);
        // Reset in mid-run returns the defaults
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        rd(4'h0, 8'h00);
        rd(4'h3, 8'hff);
        rd(4'h5, 8'h00);
        $display("Test freeze and reset done");
        test_done();
    end
endmodule : pri_ctrl_tb
